// ==== design/io_ctrl_pkg.sv ====
// Package with the register map, field positions and widths of the port and timer control block.
`default_nettype none
package io_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int HALF_W = 16;
   localparam int PORT_N = 4;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'hF8;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'hF0;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'hF1;

   // Field positions of the control register.
   localparam int FLOAT_BIT = 0;
   localparam int HIGHZ_LO_BIT = 1;
   localparam int HIGHZ_HI_BIT = 3;
   localparam int PULLUP_OFF_BIT = 4;
   localparam int SERIAL_ERR_BIT = 5;
   localparam int CASCADE_BIT = 6;
   localparam int TOP_BIT = 7;

   // Field positions of the interrupt status and mask registers.
   localparam int IRQ_T0_BIT = 0;
   localparam int IRQ_T1_BIT = 1;
   localparam int IRQ_SERR_BIT = 2;
   localparam int IRQ_N = 3;

   // Reset values, the control write mask, the idle read value and counter constants.
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 8'h7F;
   localparam logic [IRQ_N-1:0] IRQ_RESET = 3'h0;
   localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
   localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;
   localparam logic [HALF_W-1:0] HALF_MAX = 16'hFFFF;
   localparam logic [HALF_W-1:0] HALF_ONE = 16'h0001;
endpackage : io_ctrl_pkg
`default_nettype wire

// ==== design/timer_link_if.sv ====
// Interface joining the control register logic and the cascadable timer pair.
`default_nettype none
interface timer_link_if;
   logic cascade;
   logic count0;
   logic count1;
   logic ovf0;
   logic ovf1;
   logic [2*io_ctrl_pkg::HALF_W-1:0] value;

   modport ctrl (output cascade, output count0, output count1, input ovf0, input ovf1, input value);
   modport timer (input cascade, input count0, input count1, output ovf0, output ovf1, output value);
endinterface : timer_link_if
`default_nettype wire

// ==== design/timer_pair.sv ====
// Two 16-bit timer/counters that can be chained into one 32-bit counter.
`default_nettype none
module timer_pair (
   input wire logic clk_in,
   input wire logic srst_in,
   timer_link_if.timer link
);
   logic [io_ctrl_pkg::HALF_W-1:0] low;
   logic [io_ctrl_pkg::HALF_W-1:0] high;
   logic carry_low;
   logic step_high;
   logic carry_high;

   // True when a count step wraps the given half.
   function automatic logic wraps(input logic [io_ctrl_pkg::HALF_W-1:0] v, input logic step);
      wraps = step && (v == io_ctrl_pkg::HALF_MAX);
   endfunction : wraps

   // In cascade the high half counts the low half's carries instead of its own input.
   assign carry_low = wraps(low, link.count0);
   assign step_high = link.cascade ? carry_low : link.count1;
   assign carry_high = wraps(high, step_high);

   ////////////////////////////////////////////////////////////////////////////
   // Counter halves.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         low <= io_ctrl_pkg::HALF_RESET;
         high <= io_ctrl_pkg::HALF_RESET;
      end else begin
         if (link.count0) begin
            low <= low + io_ctrl_pkg::HALF_ONE;
         end
         if (step_high) begin
            high <= high + io_ctrl_pkg::HALF_ONE;
         end
      end
   end

   // Overflow pulses; the low half's carry is internal while chained.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         link.ovf0 <= 1'b0;
         link.ovf1 <= 1'b0;
      end else begin
         link.ovf0 <= carry_low && !link.cascade;
         link.ovf1 <= carry_high;
      end
   end

   assign link.value = {high, low};

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_chain_carry: assert property (@(posedge clk_in) disable iff (srst_in)
      link.cascade && link.count0 && low == io_ctrl_pkg::HALF_MAX && high == io_ctrl_pkg::HALF_MAX
      |=> link.ovf1 && !link.ovf0 && link.value == {2*io_ctrl_pkg::HALF_W{1'b0}})
      else $error("Chained counter carry did not raise the timer one overflow.");
endmodule : timer_pair
`default_nettype wire

// ==== design/io_port_timer_ctrl.sv ====
// Port and timer control register with power-down float, port high-impedance and timer cascade.
`default_nettype none
module io_port_timer_ctrl (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [io_ctrl_pkg::ADDR_W-1:0] addr_in,
   input wire logic [io_ctrl_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [io_ctrl_pkg::DATA_W-1:0] rdata_out,
   input wire logic power_down_mode_in,
   input wire logic hard_power_down_mode_in,
   input wire logic serial_error_in,
   input wire logic timer_zero_count_in,
   input wire logic timer_one_count_in,
   output logic [io_ctrl_pkg::PORT_N-1:0] port_oe_n_out,
   output logic pullup_strong_off_out,
   output logic timer_one_overflow_flag_out,
   output logic timer_zero_overflow_out,
   output logic irq_out
);
   logic [io_ctrl_pkg::DATA_W-1:0] io_port_timer_control;
   logic [io_ctrl_pkg::IRQ_N-1:0] irq_status;
   logic [io_ctrl_pkg::IRQ_N-1:0] irq_mask;
   logic [io_ctrl_pkg::IRQ_N-1:0] irq_events;
   logic [io_ctrl_pkg::IRQ_N-1:0] irq_clear;
   logic wr_ctrl;
   logic serial_err_clear;
   logic sleeping;
   logic float_all;

   timer_link_if link ();

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.
   assign wr_ctrl = wr_in && (addr_in == io_ctrl_pkg::CTRL_ADDR);
   assign serial_err_clear = wr_ctrl && !wdata_in[io_ctrl_pkg::SERIAL_ERR_BIT];

   // Control register: plain fields follow writes, the error flag is set by hardware and cleared by a zero write.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         io_port_timer_control <= io_ctrl_pkg::CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            io_port_timer_control <= wdata_in & io_ctrl_pkg::CTRL_WRITE_MASK;
            io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT] <= io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT];
         end
         // A new error in the clearing cycle wins over the clear.
         if (serial_error_in) begin
            io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT] <= 1'b1;
         end else if (serial_err_clear) begin
            io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT] <= 1'b0;
         end
         io_port_timer_control[io_ctrl_pkg::TOP_BIT] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port drive control; an enable low means the port is driven.
   assign sleeping = power_down_mode_in || hard_power_down_mode_in;
   assign float_all = sleeping && io_port_timer_control[io_ctrl_pkg::FLOAT_BIT];

   // Port zero floats only in sleep; ports one to three also follow their own bits.
   always_comb begin
      port_oe_n_out[0] = float_all;
      for (int i = 1; i < io_ctrl_pkg::PORT_N; i++) begin
         port_oe_n_out[i] = float_all || io_port_timer_control[io_ctrl_pkg::HIGHZ_LO_BIT + i - 1];
      end
   end

   assign pullup_strong_off_out = io_port_timer_control[io_ctrl_pkg::PULLUP_OFF_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Timer pair.
   assign link.cascade = io_port_timer_control[io_ctrl_pkg::CASCADE_BIT];
   assign link.count0 = timer_zero_count_in;
   assign link.count1 = timer_one_count_in;

   timer_pair timers (
      .clk_in (clk_in),
      .srst_in (srst_in),
      .link (link.timer)
   );

   // Overflow pulses towards the timer control register.
   assign timer_one_overflow_flag_out = link.ovf1;
   assign timer_zero_overflow_out = link.ovf0;

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, write one to clear, a set in the same cycle wins.
   assign irq_events = {serial_error_in, link.ovf1, link.ovf0};
   assign irq_clear = (wr_in && addr_in == io_ctrl_pkg::IRQ_STATUS_ADDR) ? wdata_in[io_ctrl_pkg::IRQ_N-1:0] :
                      io_ctrl_pkg::IRQ_RESET;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_status <= io_ctrl_pkg::IRQ_RESET;
      end else begin
         irq_status <= (irq_status & ~irq_clear) | irq_events;
      end
   end

   // Interrupt mask.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_mask <= io_ctrl_pkg::IRQ_RESET;
      end else if (wr_in && addr_in == io_ctrl_pkg::IRQ_MASK_ADDR) begin
         irq_mask <= wdata_in[io_ctrl_pkg::IRQ_N-1:0];
      end
   end

   assign irq_out = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the read strobe; unmapped addresses read zero.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_out <= io_ctrl_pkg::READ_IDLE;
      end else if (rd_in) begin
         case (addr_in)
            io_ctrl_pkg::CTRL_ADDR: rdata_out <= io_port_timer_control & io_ctrl_pkg::CTRL_WRITE_MASK;
            io_ctrl_pkg::IRQ_STATUS_ADDR: rdata_out <= {{(io_ctrl_pkg::DATA_W-io_ctrl_pkg::IRQ_N){1'b0}}, irq_status};
            io_ctrl_pkg::IRQ_MASK_ADDR: rdata_out <= {{(io_ctrl_pkg::DATA_W-io_ctrl_pkg::IRQ_N){1'b0}}, irq_mask};
            default: rdata_out <= io_ctrl_pkg::READ_IDLE;
         endcase
      end else begin
         rdata_out <= io_ctrl_pkg::READ_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_sleep_float_all: assert property (@(posedge clk_in) disable iff (srst_in)
      sleeping && io_port_timer_control[io_ctrl_pkg::FLOAT_BIT] |-> port_oe_n_out == {io_ctrl_pkg::PORT_N{1'b1}})
      else $error("Ports not all floating in power-down with float bit set.");

   a_ports_stay_driven: assert property (@(posedge clk_in) disable iff (srst_in)
      !io_port_timer_control[io_ctrl_pkg::FLOAT_BIT] |-> !port_oe_n_out[0] &&
      port_oe_n_out[io_ctrl_pkg::PORT_N-1:1] == io_port_timer_control[io_ctrl_pkg::HIGHZ_HI_BIT:io_ctrl_pkg::HIGHZ_LO_BIT])
      else $error("Port left output mode while float bit is clear.");

   a_highz_write: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_ctrl && wdata_in[io_ctrl_pkg::HIGHZ_HI_BIT:io_ctrl_pkg::HIGHZ_LO_BIT] == 3'h7
      |=> port_oe_n_out[io_ctrl_pkg::PORT_N-1:1] == 3'h7)
      else $error("High-impedance bits did not release ports one to three.");

   a_cascade_carry_flag: assert property (@(posedge clk_in) disable iff (srst_in)
      link.cascade && timer_zero_count_in && link.value == {2*io_ctrl_pkg::HALF_W{1'b1}}
      |=> timer_one_overflow_flag_out ##1 !timer_one_overflow_flag_out)
      else $error("Chained carry did not give a one-cycle timer one overflow.");

   a_top_bit_zero: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_in && addr_in == io_ctrl_pkg::CTRL_ADDR |=> !rdata_out[io_ctrl_pkg::TOP_BIT])
      else $error("Top control bit read back as one.");

   a_drive_restored: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_ctrl && !wdata_in[io_ctrl_pkg::HIGHZ_LO_BIT] && !wdata_in[io_ctrl_pkg::FLOAT_BIT]
      |=> !port_oe_n_out[1])
      else $error("Port one not driven right after clearing its high-impedance bit.");

   a_irq_sticky: assert property (@(posedge clk_in) disable iff (srst_in)
      link.ovf1 |=> irq_status[io_ctrl_pkg::IRQ_T1_BIT] && (!irq_mask[io_ctrl_pkg::IRQ_T1_BIT] || irq_out))
      else $error("Timer one overflow was not held in the status register.");

   a_read_one_cycle: assert property (@(posedge clk_in) disable iff (srst_in)
      !rd_in |=> rdata_out == io_ctrl_pkg::READ_IDLE)
      else $error("Read data stood outside the cycle after a read.");

   ////////////////////////////////////////////////////////////////////////////
   // Further checks, one port, input, flag or bit at a time save the write and read checks: port drive, then cascade, control fields, interrupts and reads.
   // Port zero floats whenever the float condition holds.
   a_float_port_zero: assert property (@(posedge clk_in) disable iff (srst_in)
      float_all |-> port_oe_n_out[0])
      else $error("Port zero still driven while floating is requested.");

   // Hard power-down alone, with the float bit set, is enough to float every port.
   a_float_hard_only: assert property (@(posedge clk_in) disable iff (srst_in)
      hard_power_down_mode_in && io_port_timer_control[io_ctrl_pkg::FLOAT_BIT] |-> &port_oe_n_out)
      else $error("Ports not floating in hard power-down with float bit set.");

   // Plain power-down alone, with the float bit set, is enough to float every port.
   a_float_soft_only: assert property (@(posedge clk_in) disable iff (srst_in)
      power_down_mode_in && io_port_timer_control[io_ctrl_pkg::FLOAT_BIT] |-> &port_oe_n_out)
      else $error("Ports not floating in power-down with float bit set.");

   // Port zero is always driven while the core is awake.
   a_port_zero_awake: assert property (@(posedge clk_in) disable iff (srst_in)
      !sleeping |-> !port_oe_n_out[0])
      else $error("Port zero floating while the core is awake.");

   // Port zero stays driven in power-down when the float bit is clear.
   a_clear_float_sleep: assert property (@(posedge clk_in) disable iff (srst_in)
      sleeping && !io_port_timer_control[io_ctrl_pkg::FLOAT_BIT] |-> !port_oe_n_out[0])
      else $error("Port zero floating in power-down with float bit clear.");

   // Each high-impedance bit releases its own port.
   a_highz_port_one: assert property (@(posedge clk_in) disable iff (srst_in)
      io_port_timer_control[io_ctrl_pkg::HIGHZ_LO_BIT] |-> port_oe_n_out[1])
      else $error("Port one driven with its high-impedance bit set.");

   a_highz_port_two: assert property (@(posedge clk_in) disable iff (srst_in)
      io_port_timer_control[io_ctrl_pkg::HIGHZ_LO_BIT + 1] |-> port_oe_n_out[2])
      else $error("Port two driven with its high-impedance bit set.");

   a_highz_port_three: assert property (@(posedge clk_in) disable iff (srst_in)
      io_port_timer_control[io_ctrl_pkg::HIGHZ_HI_BIT] |-> port_oe_n_out[3])
      else $error("Port three driven with its high-impedance bit set.");

   // The cascade bit follows the last control write.
   a_cascade_bit_write: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_ctrl |=> link.cascade == $past(wdata_in[io_ctrl_pkg::CASCADE_BIT]))
      else $error("Cascade bit did not follow the control write.");

   // While chained, the low half never reports an overflow of its own.
   a_cascade_no_ovf0: assert property (@(posedge clk_in) disable iff (srst_in)
      link.cascade |=> !link.ovf0)
      else $error("Timer zero overflow pulsed while the timers are chained.");

   // The top bit is never stored.
   a_top_bit_stored: assert property (@(posedge clk_in) disable iff (srst_in)
      !io_port_timer_control[io_ctrl_pkg::TOP_BIT])
      else $error("Top control bit held a one.");

   // A one written to the top bit is dropped.
   a_top_write_dropped: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_ctrl && wdata_in[io_ctrl_pkg::TOP_BIT] |=> !io_port_timer_control[io_ctrl_pkg::TOP_BIT])
      else $error("A one written to the top control bit was kept.");

   // The plain fields take the written value right after the write edge.
   a_ctrl_write_lands: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_ctrl |=> io_port_timer_control[io_ctrl_pkg::PULLUP_OFF_BIT:io_ctrl_pkg::FLOAT_BIT] ==
      $past(wdata_in[io_ctrl_pkg::PULLUP_OFF_BIT:io_ctrl_pkg::FLOAT_BIT]))
      else $error("Control write did not land right after its edge.");

   // A clear high-impedance bit keeps port three driven while awake or not floating.
   a_highz_clear_drives: assert property (@(posedge clk_in) disable iff (srst_in)
      !io_port_timer_control[io_ctrl_pkg::HIGHZ_HI_BIT] && !float_all |-> !port_oe_n_out[3])
      else $error("Port three floating with its high-impedance bit clear.");

   // The pull-up output mirrors its control bit.
   a_pullup_mirror: assert property (@(posedge clk_in) disable iff (srst_in)
      pullup_strong_off_out == io_port_timer_control[io_ctrl_pkg::PULLUP_OFF_BIT])
      else $error("Pull-up output differs from its control bit.");

   // A serial error always sets the flag, even against a clearing write.
   a_serr_set_wins: assert property (@(posedge clk_in) disable iff (srst_in)
      serial_error_in |=> io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT])
      else $error("Serial error did not set the error flag.");

   // A zero written to the flag clears it when no new error arrives.
   a_serr_cleared: assert property (@(posedge clk_in) disable iff (srst_in)
      serial_err_clear && !serial_error_in |=> !io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT])
      else $error("Serial error flag not cleared by a zero write.");

   // A one written to the flag leaves it as it was.
   a_serr_write_keeps: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_ctrl && wdata_in[io_ctrl_pkg::SERIAL_ERR_BIT] && !serial_error_in
      |=> io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT] == $past(io_port_timer_control[io_ctrl_pkg::SERIAL_ERR_BIT]))
      else $error("Writing one changed the serial error flag.");

   // Writing one to a status bit clears it when no new event arrives.
   a_status_clear: assert property (@(posedge clk_in) disable iff (srst_in)
      irq_clear[io_ctrl_pkg::IRQ_T0_BIT] && !irq_events[io_ctrl_pkg::IRQ_T0_BIT]
      |=> !irq_status[io_ctrl_pkg::IRQ_T0_BIT])
      else $error("Timer zero status bit not cleared by a one write.");

   // A status bit stays set until software clears it.
   a_status_holds: assert property (@(posedge clk_in) disable iff (srst_in)
      irq_status[io_ctrl_pkg::IRQ_T0_BIT] && !irq_clear[io_ctrl_pkg::IRQ_T0_BIT]
      |=> irq_status[io_ctrl_pkg::IRQ_T0_BIT])
      else $error("Timer zero status bit dropped without a clear.");

   // The mask takes the written value.
   a_mask_write: assert property (@(posedge clk_in) disable iff (srst_in)
      wr_in && addr_in == io_ctrl_pkg::IRQ_MASK_ADDR |=> irq_mask == $past(wdata_in[io_ctrl_pkg::IRQ_N-1:0]))
      else $error("Interrupt mask did not take the written value.");

   // Reading the status returns it, zero padded.
   a_status_read: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_in && addr_in == io_ctrl_pkg::IRQ_STATUS_ADDR
      |=> rdata_out == {{(io_ctrl_pkg::DATA_W-io_ctrl_pkg::IRQ_N){1'b0}}, $past(irq_status)})
      else $error("Status read returned a wrong value.");

   // Reading the control register returns the stored fields.
   a_ctrl_read: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_in && addr_in == io_ctrl_pkg::CTRL_ADDR
      |=> rdata_out == ($past(io_port_timer_control) & io_ctrl_pkg::CTRL_WRITE_MASK))
      else $error("Control read returned a wrong value.");

   // Unmapped addresses read zero.
   a_unmapped_read: assert property (@(posedge clk_in) disable iff (srst_in)
      rd_in && addr_in != io_ctrl_pkg::CTRL_ADDR && addr_in != io_ctrl_pkg::IRQ_STATUS_ADDR &&
      addr_in != io_ctrl_pkg::IRQ_MASK_ADDR |=> rdata_out == io_ctrl_pkg::READ_IDLE)
      else $error("Unmapped address read returned nonzero data.");

   c_serr_cleared: cover property (@(posedge clk_in) disable iff (srst_in) serial_err_clear);
   c_highz_all: cover property (@(posedge clk_in) disable iff (srst_in) &port_oe_n_out[io_ctrl_pkg::PORT_N-1:1]);
   c_sleep_float: cover property (@(posedge clk_in) disable iff (srst_in) float_all);
   c_chain_carry: cover property (@(posedge clk_in) disable iff (srst_in) link.cascade && link.ovf1);
   c_irq_raised: cover property (@(posedge clk_in) disable iff (srst_in) $rose(irq_out));
endmodule : io_port_timer_ctrl
`default_nettype wire

// ==== bench/io_port_timer_ctrl_tb.sv ====
// Self-checking testbench of the port and timer control register block.
`default_nettype none
`define CHK(g, e) check(g, e)
module io_port_timer_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic pd = 1'b0;
   logic hard_power_down_mode = 1'b0;
   logic serr = 1'b0;
   logic cnt0 = 1'b0;
   logic cnt1 = 1'b0;
   logic [7:0] rdata_out;
   logic [3:0] port_oe_n_out;
   logic pullup_out, ovf1_out, ovf0_out, irq_out;
   logic rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   int n_mismatch = 0;
   int checked = 0;
   int n_ovf0 = 0;
   int n_ovf1 = 0;
   int seed = 66450;
   logic [7:0] d;
   logic f;

   io_port_timer_ctrl i_dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .power_down_mode_in(pd),
      .hard_power_down_mode_in(hard_power_down_mode), .serial_error_in(serr), .timer_zero_count_in(cnt0),
      .timer_one_count_in(cnt1), .port_oe_n_out(port_oe_n_out), .pullup_strong_off_out(pullup_out),
      .timer_one_overflow_flag_out(ovf1_out), .timer_zero_overflow_out(ovf0_out), .irq_out(irq_out));

   // Clock of 4 ns period.
   initial begin
      forever #2 clk_in = ~clk_in;
   end

   // Compares one result with its expectation and counts the outcome.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d.", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // One write cycle on the register port.
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : reg_wr

   // One read cycle; the expected data is queued for the monitor.
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask : reg_rd

   // Monitor: read data stands in the cycle after the strobe; overflow pulses are counted.
   always @(posedge clk_in) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            `CHK(1'b1, 1'b0);
         end else begin
            `CHK(rdata_out, exp_q.pop_front());
         end
      end
      rd_seen <= rd_in;
      if (ovf0_out === 1'b1) n_ovf0++;
      if (ovf1_out === 1'b1) n_ovf1++;
   end

   // Watchdog so that a hang still reaches the verdict.
   initial begin
      repeat (100000) @(posedge clk_in);
      n_mismatch++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      reg_rd(8'hF8, 8'h00);
      reg_rd(8'hF0, 8'h00);
      reg_rd(8'hF1, 8'h00);
      `CHK(port_oe_n_out, 4'h0);
      // Every float, high-impedance and power-down combination, random upper bits included.
      for (int k = 0; k < 64; k++) begin
         d = 8'($random(seed));
         d[3:0] = k[3:0];
         pd <= k[4];
         hard_power_down_mode <= k[5];
         reg_wr(8'hF8, d);
         #1;
         f = d[0] & (k[4] | k[5]);
         `CHK(port_oe_n_out, {f | d[3], f | d[2], f | d[1], f});
         `CHK(pullup_out, d[4]);
         reg_rd(8'hF8, d & 8'h5F);
      end
      pd <= 1'b0;
      hard_power_down_mode <= 1'b0;
      reg_wr(8'hF8, 8'h00);
      // Separate halves: both wrap after 65536 steps.
      cnt0 <= 1'b1;
      cnt1 <= 1'b1;
      repeat (65536) @(posedge clk_in);
      cnt0 <= 1'b0;
      cnt1 <= 1'b0;
      repeat (3) @(posedge clk_in);
      `CHK(n_ovf0, 1);
      `CHK(n_ovf1, 1);
      // Cascaded: timer one input is ignored and no half wraps on its own.
      reg_wr(8'hF8, 8'h40);
      cnt0 <= 1'b1;
      cnt1 <= 1'b1;
      repeat (200) @(posedge clk_in);
      cnt0 <= 1'b0;
      cnt1 <= 1'b0;
      repeat (3) @(posedge clk_in);
      `CHK(n_ovf0 + n_ovf1, 2);
      reg_rd(8'hF0, 8'h03);
      `CHK(irq_out, 1'b0);
      reg_wr(8'hF1, 8'h02);
      #1;
      `CHK(irq_out, 1'b1);
      reg_wr(8'hF0, 8'h02);
      #1;
      `CHK(irq_out, 1'b0);
      reg_rd(8'hF0, 8'h01);
      // Serial error sets the flag bit and the status bit.
      @(posedge clk_in);
      serr <= 1'b1;
      @(posedge clk_in);
      serr <= 1'b0;
      reg_rd(8'hF8, 8'h60);
      reg_rd(8'hF0, 8'h05);
      reg_wr(8'hF1, 8'h04);
      #1;
      `CHK(irq_out, 1'b1);
      reg_wr(8'hF8, 8'hC0);
      reg_rd(8'hF8, 8'h40);
      reg_wr(8'hF0, 8'h05);
      #1;
      `CHK(irq_out, 1'b0);
      // Unmapped place: write ignored, reads zero.
      reg_wr(8'hF5, 8'h55);
      reg_rd(8'hF5, 8'h00);
      reg_rd(8'hF8, 8'h40);
      // Reset in mid-run clears the control register.
      @(posedge clk_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      reg_rd(8'hF8, 8'h00);
      repeat (3) @(posedge clk_in);
      `CHK(exp_q.size(), 0);
      report_and_stop();
   end
endmodule : io_port_timer_ctrl_tb
`default_nettype wire
